// file: common/riop_cfg.svh
// constants for the ram and io port block with port a edge detector
`ifndef RIOP_CFG_SVH
`define RIOP_CFG_SVH
`define RIOP_RAM_WORDS   128
`define RIOP_ADDR_W      7
`define RIOP_DATA_W      8
`define RIOP_ZERO8       8'h00
`define RIOP_OFF_PA_DATA 7'h00
`define RIOP_OFF_PA_DIR  7'h01
`define RIOP_OFF_PB_DATA 7'h02
`define RIOP_OFF_PB_DIR  7'h03
`define RIOP_OFF_FLAGS   7'h05
`define RIOP_EDGE_SEL    3'h1
`define RIOP_BIT_EDGE_LINE 7
`define RIOP_BIT_TIMER_FLAG 7
`define RIOP_BIT_EDGE_FLAG 6
`define RIOP_HREG_CMD    4'h0
`define RIOP_HREG_ADDR   4'h1
`define RIOP_HREG_WDATA  4'h2
`define RIOP_HREG_RDATA  4'h3
`define RIOP_HREG_STATUS 4'h4
`define RIOP_HREG_IRQ    4'h5
`endif

// file: common/riop_pkg.sv
// types for the ram and io port block, used by the host end only
package riop_pkg;
	typedef logic [7:0] riop_byte_t;
	typedef enum logic [1:0] {
		RIOP_IDLE = 2'b00,
		RIOP_BUS  = 2'b01,
		RIOP_DONE = 2'b10
	} riop_state_t;
endpackage

// file: common/riop_if.sv
// processor bus between the controller and the ram and io port device
`timescale 1ns/1ps
`default_nettype none
interface riop_if;
	// address and control, driven by the processor side
	logic [6:0] cpu_address_lines;
	logic       ram_select_n;
	logic       chip_select_high;
	logic       chip_select_low_n;
	logic       rw;
	logic       reset_n_in;
	// data bus: each end drives with its own enable, low means driving
	logic [7:0] cpu_data_bus_host;
	logic       cpu_data_bus_host_oe_n;
	logic [7:0] cpu_data_bus_dev;
	logic       cpu_data_bus_dev_oe_n;
	// open-drain interrupt, low enable means pulling the line down
	logic       irq_oe_n;
	modport device (
		input  cpu_address_lines, ram_select_n, chip_select_high, chip_select_low_n, rw, reset_n_in,
		input  cpu_data_bus_host, cpu_data_bus_host_oe_n,
		output cpu_data_bus_dev, cpu_data_bus_dev_oe_n, irq_oe_n
	);
	modport host (
		output cpu_address_lines, ram_select_n, chip_select_high, chip_select_low_n, rw, reset_n_in,
		output cpu_data_bus_host, cpu_data_bus_host_oe_n,
		input  cpu_data_bus_dev, cpu_data_bus_dev_oe_n, irq_oe_n
	);
endinterface
`default_nettype wire

// file: design/riop_ram.sv
// 128 byte static storage for the device end
`timescale 1ns/1ps
`default_nettype none
`include "riop_cfg.svh"
module riop_ram (
	// clock
	input  wire logic       mclk,
	// access
	input  wire logic       wr_en,
	input  wire logic [6:0] addr,
	input  wire logic [7:0] wdata,
	output var  logic [7:0] rdata
);
	logic [7:0] mem_r [0:`RIOP_RAM_WORDS-1];

	// no reset: contents are undefined after power-up like any static ram
	always_ff @(posedge mclk) begin
		if (wr_en) begin
			mem_r[addr] <= wdata; // RQ12
		end
	end

	always_comb begin
		rdata = mem_r[addr]; // RQ12
	end
endmodule // riop_ram
`default_nettype wire

// file: design/riop_dev.sv
// device end: ram, two io ports, port a edge detector and interrupt
//
// Overview of operation
// RQ1 - reset clears both direction and output registers
// RQ2 - reset floats data bus, disables interrupts (only the edge irq here; timer timeout has no enable)
// RQ3 - reset held low at least one clock
// RQ4 - read when rw high, write when low
// RQ5 - open-drain low interrupt from edge or timer
// RQ6 - drive data bus only on selected read
// RQ7 - direction bit 0 input, 1 output
// RQ8 - port a output lines drive output register
// RQ9 - port a read returns pin levels
// RQ10 - output writes stored while line is input
// RQ11 - select when high select 1, low 0
// RQ12 - seven address lines pick one of 128 bytes
// RQ13 - active edge on bit 7 sets flag bit 6
// RQ14 - flag and enable pull interrupt low
// RQ15 - edge-control write: a0 polarity, a1 enable
// RQ16 - flag sets regardless of direction or enable
// RQ17 - reset disables edge irq, selects falling edge
// RQ18 - software clears flag before enabling edge irq
// RQ19 - reading flag register clears edge flag
// RQ20 - software keeps bit 7 input for edges
// RQ21 - port b has own direction and output
// RQ22 - port b read returns output register
// RQ23 - flags read: timer bit 7, edge bit 6
// RQ24 - register select decode when ram select high
//
// Chosen here: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "riop_cfg.svh"
module riop_dev (
	// clock
	input  wire logic       mclk,
	// processor bus
	riop_if.device          bus,
	// peripheral port a, enable low while driving
	input  wire logic [7:0] port_a_lines_in,
	output var  logic [7:0] port_a_lines_out,
	output var  logic [7:0] port_a_lines_oe_n,
	// peripheral port b, enable low while driving
	input  wire logic [7:0] port_b_lines_in,
	output var  logic [7:0] port_b_lines_out,
	output var  logic [7:0] port_b_lines_oe_n,
	// timeout from the interval timer, a level
	input  wire logic       timer_timeout
);
	////////////////////////////////////////////////////////////////////////
	logic [7:0] port_a_output_r;
	logic [7:0] port_a_direction_r;
	logic [7:0] port_b_output_r;
	logic [7:0] port_b_direction_r;
	logic       edge_rising_r;
	logic       edge_irq_en_r;
	logic       edge_flag_r;
	logic       edge_line_d_r;
	logic [7:0] data_out_r;
	logic       data_oe_n_r;
	logic       irq_oe_n_r;
	logic       rst;
	logic       sel;
	logic       wr;
	logic       rd;
	logic       ram_acc;
	logic       edge_evt;
	logic [7:0] ram_rdata;
	logic [7:0] rd_mux;
	logic [7:0] flag_byte;

	assign rst      = ~bus.reset_n_in;
	assign sel      = bus.chip_select_high & ~bus.chip_select_low_n; // RQ11
	assign wr       = sel & ~bus.rw; // RQ4
	assign rd       = sel & bus.rw; // RQ4
	assign ram_acc  = ~bus.ram_select_n; // RQ11

	function automatic logic reg_hit(input logic [6:0] a, input logic [6:0] off);
		reg_hit = (a == off);
	endfunction

	////////////////////////////////////////////////////////////////////////
	riop_ram u_ram (
		.mclk  (mclk),
		.wr_en (wr & ram_acc),
		.addr  (bus.cpu_address_lines),
		.wdata (bus.cpu_data_bus_host),
		.rdata (ram_rdata)
	);

	////////////////////////////////////////////////////////////////////////
	// port registers; writes land whatever the direction bit says
	always_ff @(posedge mclk) begin
		if (rst) begin
			port_a_output_r    <= `RIOP_ZERO8; // RQ1
			port_a_direction_r <= `RIOP_ZERO8; // RQ1
			port_b_output_r    <= `RIOP_ZERO8; // RQ1
			port_b_direction_r <= `RIOP_ZERO8; // RQ1
		end else if (wr && !ram_acc) begin // RQ24
			if (reg_hit(bus.cpu_address_lines, `RIOP_OFF_PA_DATA)) begin
				port_a_output_r <= bus.cpu_data_bus_host; // RQ10
			end else if (reg_hit(bus.cpu_address_lines, `RIOP_OFF_PA_DIR)) begin
				port_a_direction_r <= bus.cpu_data_bus_host;
			end else if (reg_hit(bus.cpu_address_lines, `RIOP_OFF_PB_DATA)) begin
				port_b_output_r <= bus.cpu_data_bus_host; // RQ21
			end else if (reg_hit(bus.cpu_address_lines, `RIOP_OFF_PB_DIR)) begin
				port_b_direction_r <= bus.cpu_data_bus_host; // RQ21
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// edge control: address bits 6:4 pick the sixteen control addresses, data ignored
	always_ff @(posedge mclk) begin
		if (rst) begin
			edge_rising_r <= 1'b0; // RQ17
			edge_irq_en_r <= 1'b0; // RQ17
		end else if (wr && !ram_acc && bus.cpu_address_lines[6:4] == `RIOP_EDGE_SEL) begin
			edge_rising_r <= bus.cpu_address_lines[0]; // RQ15
			edge_irq_en_r <= bus.cpu_address_lines[1]; // RQ15
		end
	end

	// the edge line is watched at the pin, so an output drive also counts
	assign edge_evt = edge_rising_r ?
		(~edge_line_d_r & port_a_lines_in[`RIOP_BIT_EDGE_LINE]) :
		(edge_line_d_r & ~port_a_lines_in[`RIOP_BIT_EDGE_LINE]); // RQ13

	// no reset here: the delayed copy follows the pin through reset as well,
	// so a pin that is low when reset ends is not taken for a falling edge
	always_ff @(posedge mclk) begin
		edge_line_d_r <= port_a_lines_in[`RIOP_BIT_EDGE_LINE];
	end

	// set wins over the read clear so an edge in the read cycle is kept
	always_ff @(posedge mclk) begin
		if (rst) begin
			edge_flag_r <= 1'b0;
		end else if (edge_evt) begin
			edge_flag_r <= 1'b1; // RQ16
		end else if (rd && !ram_acc && reg_hit(bus.cpu_address_lines, `RIOP_OFF_FLAGS)) begin
			edge_flag_r <= 1'b0; // RQ19
		end
	end

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		flag_byte = `RIOP_ZERO8; // RQ23
		flag_byte[`RIOP_BIT_TIMER_FLAG] = timer_timeout; // RQ23
		flag_byte[`RIOP_BIT_EDGE_FLAG]  = edge_flag_r; // RQ23
	end

	// addresses with no register behind them read as zero
	always_comb begin
		rd_mux = `RIOP_ZERO8;
		if (ram_acc) begin
			rd_mux = ram_rdata; // RQ12
		end else if (reg_hit(bus.cpu_address_lines, `RIOP_OFF_PA_DATA)) begin
			rd_mux = port_a_lines_in; // RQ9
		end else if (reg_hit(bus.cpu_address_lines, `RIOP_OFF_PA_DIR)) begin
			rd_mux = port_a_direction_r;
		end else if (reg_hit(bus.cpu_address_lines, `RIOP_OFF_PB_DATA)) begin
			rd_mux = port_b_output_r; // RQ22
		end else if (reg_hit(bus.cpu_address_lines, `RIOP_OFF_PB_DIR)) begin
			rd_mux = port_b_direction_r;
		end else if (reg_hit(bus.cpu_address_lines, `RIOP_OFF_FLAGS)) begin
			rd_mux = flag_byte;
		end
	end

	// read data stand in the cycle after the read is taken
	always_ff @(posedge mclk) begin
		if (rst) begin
			data_out_r  <= `RIOP_ZERO8;
			data_oe_n_r <= 1'b1; // RQ2
		end else begin
			data_out_r  <= rd_mux;
			data_oe_n_r <= ~rd; // RQ6
		end
	end

	// timer timeout pulls the line directly, with no enable; only the edge flag has one
	always_ff @(posedge mclk) begin
		if (rst) begin
			irq_oe_n_r <= 1'b1; // RQ2
		end else begin
			irq_oe_n_r <= ~((edge_flag_r & edge_irq_en_r) | timer_timeout); // RQ5 RQ14
		end
	end

	////////////////////////////////////////////////////////////////////////
	// pin drivers are registered; a line drives only while its direction bit is 1
	always_ff @(posedge mclk) begin
		if (rst) begin
			port_a_lines_out  <= `RIOP_ZERO8;
			port_a_lines_oe_n <= 8'hff;
			port_b_lines_out  <= `RIOP_ZERO8;
			port_b_lines_oe_n <= 8'hff;
		end else begin
			port_a_lines_out  <= port_a_output_r; // RQ8
			port_a_lines_oe_n <= ~port_a_direction_r; // RQ7
			port_b_lines_out  <= port_b_output_r; // RQ21
			port_b_lines_oe_n <= ~port_b_direction_r; // RQ7
		end
	end

	assign bus.cpu_data_bus_dev      = data_out_r;
	assign bus.cpu_data_bus_dev_oe_n = data_oe_n_r;
	assign bus.irq_oe_n              = irq_oe_n_r;
endmodule // riop_dev
`default_nettype wire

// file: design/riop_host.sv
// host end: turns register commands into processor bus cycles
`timescale 1ns/1ps
`default_nettype none
`include "riop_cfg.svh"
module riop_host (
	// clock and reset
	input  wire logic       mclk,
	input  wire logic       srst,
	// software register port
	input  wire logic [3:0] sw_addr,
	input  wire logic [7:0] sw_wdata,
	input  wire logic       sw_wr,
	input  wire logic       sw_rd,
	output var  logic [7:0] sw_rdata,
	// bus
	riop_if.host            bus
);
	////////////////////////////////////////////////////////////////////////
	riop_pkg::riop_state_t state_r;
	logic [7:0] cmd_r;
	logic [6:0] addr_r;
	logic [7:0] wdata_r;
	logic [7:0] rdata_r;
	logic       done_r;
	logic       go;

	// cmd bits: 0 go, 1 read, 2 ram select, 3 reset the device
	assign go = sw_wr && sw_addr == `RIOP_HREG_CMD && sw_wdata[0] && state_r == riop_pkg::RIOP_IDLE;

	always_ff @(posedge mclk) begin
		if (srst) begin
			cmd_r   <= `RIOP_ZERO8;
			addr_r  <= 7'h00;
			wdata_r <= `RIOP_ZERO8;
		end else if (sw_wr) begin
			if (sw_addr == `RIOP_HREG_CMD) begin
				cmd_r <= sw_wdata;
			end else if (sw_addr == `RIOP_HREG_ADDR) begin
				addr_r <= sw_wdata[6:0];
			end else if (sw_addr == `RIOP_HREG_WDATA) begin
				wdata_r <= sw_wdata;
			end
		end
	end

	// one bus cycle with selects held, then capture the device data one cycle on
	always_ff @(posedge mclk) begin
		if (srst) begin
			state_r <= riop_pkg::RIOP_IDLE;
		end else begin
			case (state_r)
				riop_pkg::RIOP_IDLE: if (go) state_r <= riop_pkg::RIOP_BUS;
				riop_pkg::RIOP_BUS:  state_r <= riop_pkg::RIOP_DONE;
				default:             state_r <= riop_pkg::RIOP_IDLE;
			endcase
		end
	end

	// done is set on completion; set wins over the clear by a status write
	always_ff @(posedge mclk) begin
		if (srst) begin
			done_r  <= 1'b0;
			rdata_r <= `RIOP_ZERO8;
		end else if (state_r == riop_pkg::RIOP_DONE) begin
			done_r <= 1'b1;
			if (cmd_r[1]) begin
				rdata_r <= bus.cpu_data_bus_dev;
			end
		end else if (sw_wr && sw_addr == `RIOP_HREG_STATUS) begin
			done_r <= 1'b0;
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			bus.chip_select_high       <= 1'b0;
			bus.chip_select_low_n      <= 1'b1;
			bus.rw                     <= 1'b1;
			bus.ram_select_n           <= 1'b1;
			bus.cpu_address_lines      <= 7'h00;
			bus.cpu_data_bus_host      <= `RIOP_ZERO8;
			bus.cpu_data_bus_host_oe_n <= 1'b1;
			bus.reset_n_in             <= 1'b0; // RQ3
		end else begin
			bus.reset_n_in        <= ~cmd_r[3]; // RQ3
			bus.chip_select_high  <= go; // RQ11
			bus.chip_select_low_n <= ~go; // RQ11
			bus.rw                <= go ? sw_wdata[1] : 1'b1; // RQ4
			bus.ram_select_n      <= ~(go & sw_wdata[2]);
			bus.cpu_address_lines <= addr_r;
			bus.cpu_data_bus_host <= wdata_r;
			bus.cpu_data_bus_host_oe_n <= ~(go & ~sw_wdata[1]);
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			sw_rdata <= `RIOP_ZERO8;
		end else if (sw_rd) begin
			if (sw_addr == `RIOP_HREG_CMD) begin
				sw_rdata <= cmd_r;
			end else if (sw_addr == `RIOP_HREG_ADDR) begin
				sw_rdata <= {1'b0, addr_r};
			end else if (sw_addr == `RIOP_HREG_WDATA) begin
				sw_rdata <= wdata_r;
			end else if (sw_addr == `RIOP_HREG_RDATA) begin
				sw_rdata <= rdata_r;
			end else if (sw_addr == `RIOP_HREG_STATUS) begin
				sw_rdata <= {6'h00, state_r != riop_pkg::RIOP_IDLE, done_r};
			end else if (sw_addr == `RIOP_HREG_IRQ) begin
				sw_rdata <= {7'h00, ~bus.irq_oe_n}; // RQ5
			end else begin
				sw_rdata <= `RIOP_ZERO8;
			end
		end else begin
			sw_rdata <= `RIOP_ZERO8;
		end
	end
endmodule // riop_host
`default_nettype wire

// file: sim/riop_bus_properties.sv
// checker: processor bus properties between the host and device ends
`timescale 1ns/1ps
`default_nettype none
`include "riop_cfg.svh"
module riop_bus_chk (
	// clock and reset
	input wire logic       mclk,
	input wire logic       srst,
	// bus
	input wire logic [6:0] cpu_address_lines,
	input wire logic       ram_select_n,
	input wire logic       chip_select_high,
	input wire logic       chip_select_low_n,
	input wire logic       rw,
	input wire logic       reset_n_in,
	input wire logic       cpu_data_bus_host_oe_n,
	input wire logic [7:0] cpu_data_bus_dev,
	input wire logic       cpu_data_bus_dev_oe_n,
	input wire logic       irq_oe_n
);
	default clocking @(posedge mclk); endclocking
	default disable iff (srst);
	wire logic sel;
	wire logic sel_rd;
	assign sel = chip_select_high && !chip_select_low_n;
	assign sel_rd = sel && rw && reset_n_in;
	////////////////////////////////////////////////////////////////
	AST_RESET_FLOAT: assert property (!reset_n_in |=> cpu_data_bus_dev_oe_n && irq_oe_n)
		else $error("device drives bus or irq in reset");
	AST_DRIVE_ON_READ: assert property (!cpu_data_bus_dev_oe_n |-> $past(sel_rd))
		else $error("device drives bus without a selected read");
	AST_READ_ANSWER: assert property (sel_rd |=> !cpu_data_bus_dev_oe_n)
		else $error("selected read not answered");
	AST_UNSELECTED_FLOAT: assert property (!sel |=> cpu_data_bus_dev_oe_n)
		else $error("device answers while not selected");
	AST_WRITE_NO_DRIVE: assert property (sel && !rw |=> cpu_data_bus_dev_oe_n)
		else $error("device drives bus on a write");
	AST_NO_CLASH: assert property (cpu_data_bus_host_oe_n || cpu_data_bus_dev_oe_n)
		else $error("both ends drive the data bus");
	AST_FLAG_LOW_ZERO: assert property (sel_rd && ram_select_n && cpu_address_lines == `RIOP_OFF_FLAGS
		|=> cpu_data_bus_dev[5:0] == 6'h00) else $error("flag read low bits not zero");
	AST_HOST_SEL_PULSE: assert property ($rose(sel) |=> !sel)
		else $error("select held past one cycle");
	AST_HOST_DATA_WRITE: assert property (!cpu_data_bus_host_oe_n |-> !rw && sel)
		else $error("host drives bus outside a write");
	COV_REG_READ: cover property (sel_rd && ram_select_n);
	COV_IRQ: cover property (!irq_oe_n);
	COV_DEV_RESET: cover property (!reset_n_in ##1 reset_n_in);
endmodule // riop_bus_chk
`default_nettype wire

// file: sim/testbench.sv
// testbench: host and device ends joined, software stimulus and scoreboard
`timescale 1ns/1ps
`default_nettype none
`include "riop_cfg.svh"
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin err_total++; $display("BAD t=%0t %h %h", $time, a, b); end end
module testbench;
	logic       mclk, srst, sw_wr, sw_rd, timer_timeout, rd_d, pa7;
	logic [3:0] sw_addr;
	logic [7:0] sw_wdata, sw_rdata, pa_ext, pb_ext, pa_out, pa_dir, pb_out, pb_dir, ex;
	logic [7:0] pa_in, pa_q, pa_oe_n, pb_in, pb_q, pb_oe_n;
	logic [7:0] mem [4];
	logic [7:0] expq [$];
	int         err_total, n_tests, seed, i;
	wire logic  irq;
	riop_if bus_if ();
	// pull-up on irq, pins resolve from each side's enable
	assign irq = bus_if.irq_oe_n;
	assign pa_in = (pa_oe_n & {pa7, pa_ext[6:0]}) | (~pa_oe_n & pa_q);
	assign pb_in = (pb_oe_n & pb_ext) | (~pb_oe_n & pb_q);
	riop_host riop_host_i (.mclk(mclk), .srst(srst), .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr),
		.sw_rd(sw_rd), .sw_rdata(sw_rdata), .bus(bus_if.host));
	riop_dev riop_dev_i (.mclk(mclk), .bus(bus_if.device), .port_a_lines_in(pa_in), .port_a_lines_out(pa_q),
		.port_a_lines_oe_n(pa_oe_n), .port_b_lines_in(pb_in), .port_b_lines_out(pb_q),
		.port_b_lines_oe_n(pb_oe_n), .timer_timeout(timer_timeout));
	riop_bus_chk riop_bus_chk_i (.mclk(mclk), .srst(srst), .cpu_address_lines(bus_if.cpu_address_lines),
		.ram_select_n(bus_if.ram_select_n), .chip_select_high(bus_if.chip_select_high),
		.chip_select_low_n(bus_if.chip_select_low_n), .rw(bus_if.rw), .reset_n_in(bus_if.reset_n_in),
		.cpu_data_bus_host_oe_n(bus_if.cpu_data_bus_host_oe_n), .cpu_data_bus_dev(bus_if.cpu_data_bus_dev),
		.cpu_data_bus_dev_oe_n(bus_if.cpu_data_bus_dev_oe_n), .irq_oe_n(bus_if.irq_oe_n));
	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end
	////////////////////////////////////////////////////////////////
	// read data stands only in the cycle after the strobe
	always @(posedge mclk) begin
		rd_d <= sw_rd;
		if (rd_d === 1'b1) begin
			ex = expq.pop_front();
			`CHK(sw_rdata, ex)
		end
	end
	task automatic sw_w(input logic [3:0] a, input logic [7:0] d);
		@(posedge mclk);
		sw_addr <= a;
		sw_wdata <= d;
		sw_wr <= 1'b1;
		@(posedge mclk);
		sw_wr <= 1'b0;
	endtask
	task automatic sw_r(input logic [3:0] a, input logic [7:0] e);
		@(posedge mclk);
		sw_addr <= a;
		sw_rd <= 1'b1;
		expq.push_back(e);
		@(posedge mclk);
		sw_rd <= 1'b0;
	endtask
	// done comes two edges after the command; eight leaves margin
	task automatic dev(input logic [7:0] c, input logic [7:0] a, input logic [7:0] d);
		sw_w(`RIOP_HREG_ADDR, a);
		sw_w(`RIOP_HREG_WDATA, d);
		sw_w(`RIOP_HREG_CMD, c);
		repeat (8) @(posedge mclk);
		sw_r(`RIOP_HREG_STATUS, 8'h01);
		sw_w(`RIOP_HREG_STATUS, 8'h00);
	endtask
	task automatic chk(input logic [7:0] c, input logic [7:0] a, input logic [7:0] e);
		dev(c, a, 8'h00);
		sw_r(`RIOP_HREG_RDATA, e);
	endtask
	task automatic tend(input string s);
		$display("test %s done, mismatches %0d", s, err_total);
	endtask
	task automatic final_report;
		$display("comparisons %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	initial begin
		repeat (6000) @(posedge mclk);
		err_total++;
		final_report();
	end
	////////////////////////////////////////////////////////////////
	initial begin
		seed = 71;
		{srst, pa7} = 2'b11;
		{sw_wr, sw_rd, timer_timeout} = 3'h0;
		sw_addr = 4'h0;
		sw_wdata = 8'h00;
		err_total = 0;
		n_tests = 0;
		pa_ext = 8'($random(seed));
		pb_ext = 8'($random(seed));
		repeat (6) @(posedge mclk);
		srst <= 1'b0;
		chk(8'h03, `RIOP_OFF_PA_DIR, 8'h00);
		chk(8'h03, `RIOP_OFF_PB_DATA, 8'h00);
		`CHK({pa_oe_n, pb_oe_n}, 16'hffff)
		tend("reset");
		for (i = 0; i < 4; i++) begin
			mem[i] = 8'($random(seed));
			dev(8'h05, (i == 3) ? 8'h7f : 8'(i * 8'h29), mem[i]);
		end
		for (i = 0; i < 4; i++) chk(8'h07, (i == 3) ? 8'h7f : 8'(i * 8'h29), mem[i]);
		tend("ram");
		pa_out = 8'($random(seed));
		pa_dir = 8'h5a;
		dev(8'h01, `RIOP_OFF_PA_DATA, pa_out);
		`CHK(pa_oe_n, 8'hff)
		dev(8'h01, `RIOP_OFF_PA_DIR, pa_dir);
		`CHK(pa_oe_n, ~pa_dir)
		`CHK(pa_q & pa_dir, pa_out & pa_dir)
		chk(8'h03, `RIOP_OFF_PA_DATA, (~pa_dir & {pa7, pa_ext[6:0]}) | (pa_dir & pa_out));
		pb_out = 8'($random(seed));
		pb_dir = 8'hc3;
		dev(8'h01, `RIOP_OFF_PB_DATA, pb_out);
		dev(8'h01, `RIOP_OFF_PB_DIR, pb_dir);
		`CHK({pb_oe_n, pb_q & pb_dir}, {~pb_dir, pb_out & pb_dir})
		chk(8'h03, `RIOP_OFF_PB_DATA, pb_out);
		chk(8'h03, 8'h04, 8'h00);
		tend("ports");
		chk(8'h03, `RIOP_OFF_FLAGS, 8'h00);
		pa7 <= 1'b0;
		chk(8'h03, `RIOP_OFF_FLAGS, 8'h40);
		`CHK(irq, 1'b1)
		chk(8'h03, `RIOP_OFF_FLAGS, 8'h00);
		chk(8'h03, `RIOP_OFF_FLAGS, 8'h00);
		dev(8'h01, 8'h13, 8'($random(seed)));
		pa7 <= 1'b1;
		repeat (4) @(posedge mclk);
		`CHK(irq, 1'b0)
		sw_r(`RIOP_HREG_IRQ, 8'h01);
		chk(8'h03, `RIOP_OFF_FLAGS, 8'h40);
		`CHK(irq, 1'b1)
		pa7 <= 1'b0;
		chk(8'h03, `RIOP_OFF_FLAGS, 8'h00);
		timer_timeout <= 1'b1;
		repeat (4) @(posedge mclk);
		`CHK(irq, 1'b0)
		chk(8'h03, `RIOP_OFF_FLAGS, 8'h80);
		timer_timeout <= 1'b0;
		tend("edge");
		sw_w(`RIOP_HREG_CMD, 8'h08);
		sw_w(`RIOP_HREG_CMD, 8'h00);
		chk(8'h03, `RIOP_OFF_PA_DIR, 8'h00);
		pa7 <= 1'b1;
		chk(8'h03, `RIOP_OFF_FLAGS, 8'h00);
		pa7 <= 1'b0;
		chk(8'h03, `RIOP_OFF_FLAGS, 8'h40);
		`CHK(irq, 1'b1)
		tend("device reset");
		final_report();
	end
endmodule // testbench
`default_nettype wire
